// *** inc/alm_pkg.sv ***
// Function
// - Lower light threshold is 16 bits, high byte 0x22, low byte 0x23, reset zero.
// - Filter register holds window N in bits 7:4 and hits M in 3:0, reset one.
// - Interrupt only when M of the last N results crossed the thresholds.
// - With N and M both one, any single crossing triggers the interrupt.
// - N or M of zero suppresses the light interrupt completely.
// - Config bit 7 enables unfiltered, bit 6 photopic; disabled channels are powered off.
// - Both enables zero still runs the photopic channel.
// - Bit 5 enables hysteresis; bit 4 picks upper (1) or lower (0); reset zero.
// - Range bits 3:2 select 100, analog 10, divided 10, or 1 count per lux.
// - Integration bits 1:0 select 50, 100, 200 or 400 ms; reset 50 ms.
// - Repeat mode waits interval field times 50 ms between measurements.
// - Interval zero runs measurements back to back.
// - Interval resets to ten, a 500 ms spacing.
// - Keep-powered bit 6 of interval holds sensing in low current between measurements.
// - Control bit 1 starts measurements repeatedly at the programmed interval.
// - Control bit 0 starts one measurement and clears itself when done.
// - Sensing circuitry powers down right after every measurement, except between back-to-back repeats at interval zero.
// - Without hysteresis, photopic results outside the threshold window flag an interrupt.
// - Hysteresis set/clear behaviour applies only with automatic clearing selected.
// - Unfiltered results are never compared and never cause an interrupt.
package alm_pkg;

	localparam logic [7:0] ADDR_LOW_THR_HIGH = 8'h22;
	localparam logic [7:0] ADDR_LOW_THR_LOW  = 8'h23;
	localparam logic [7:0] ADDR_FILTER       = 8'h24;
	localparam logic [7:0] ADDR_CONFIG       = 8'h25;
	localparam logic [7:0] ADDR_INTERVAL     = 8'h26;
	localparam logic [7:0] ADDR_CONTROL      = 8'h27;

	localparam logic [7:0] RST_LOW_THR   = 8'h00;
	localparam logic [7:0] RST_FILTER    = 8'h11;
	localparam logic [7:0] RST_CONFIG    = 8'h40;
	localparam logic [7:0] RST_INTERVAL  = 8'h0a;
	localparam logic [1:0] RST_CONTROL   = 2'h0;

	localparam int FILT_N_HI   = 7;
	localparam int FILT_N_LO   = 4;
	localparam int FILT_M_HI   = 3;
	localparam int FILT_M_LO   = 0;
	localparam int CFG_UNF_EN  = 7;
	localparam int CFG_PHO_EN  = 6;
	localparam int CFG_HYST_EN = 5;
	localparam int CFG_HYST_UP = 4;
	localparam int CFG_RANGE_DIV    = 3;
	localparam int CFG_RANGE_ANALOG = 2;
	localparam int CFG_INTEG_HI = 1;
	localparam int CFG_INTEG_LO = 0;
	localparam int IVL_KEEP_PWR = 6;
	localparam int IVL_HI       = 5;
	localparam int IVL_LO       = 0;
	localparam int CTL_REPEAT   = 1;
	localparam int CTL_ONESHOT  = 0;

	localparam logic [15:0] RANGE_DIVISOR = 16'h000a;

	localparam int unsigned CLK_HZ      = 20_000_000;
	localparam int unsigned STEP_MS     = 50;
	localparam int unsigned STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;

	localparam int FILT_HIST = 15;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_INTEG,
		ST_WAIT
	} alm_state_t;

endpackage

// *** core/alm_filter.sv ***
`timescale 1ns/100ps
module alm_filter
	import alm_pkg::*;
#(
	parameter int HIST_W = FILT_HIST
) (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic       sample_valid,
	input  wire logic       sample_cross,
	input  wire logic [3:0] win_n,
	input  wire logic [3:0] hits_m,
	output logic            filt_hit
);

	logic [HIST_W-1:0] hist_reg;
	logic [HIST_W-1:0] hist_next;
	logic              filt_hit_next;

	// Ones among the newest n entries of the history
	function automatic logic [4:0] count_window(input logic [HIST_W-1:0] h,
		input logic [3:0] n);
		logic [4:0] c;
		c = 5'h00;
		for (int i = 0; i < HIST_W; i++) begin
			if (i < int'(n) && h[i]) begin
				c = c + 5'h01;
			end
		end
		return c;
	endfunction

	always_comb begin
		hist_next     = {hist_reg[HIST_W-2:0], sample_cross};
		filt_hit_next = 1'b0;
		// Zero in either count disables the interrupt path
		if (sample_valid && win_n != 4'h0 && hits_m != 4'h0) begin
			// M of the last N; with 1 of 1 a single crossing is enough
			filt_hit_next = sample_cross && count_window(hist_next, win_n) >= {1'b0, hits_m};
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			hist_reg <= '0;
		end else if (sample_valid) begin
			hist_reg <= hist_next;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			filt_hit <= 1'b0;
		end else begin
			filt_hit <= filt_hit_next;
		end
	end

	chk_filter_zero_off: assert property (@(posedge sys_clk) disable iff (reset)
		(win_n == 4'h0 || hits_m == 4'h0) |=> !filt_hit)
		else $error("filter fired with a zero count");

	chk_filter_bypass_one: assert property (@(posedge sys_clk) disable iff (reset)
		(sample_valid && sample_cross && win_n == 4'h1 && hits_m == 4'h1) |=> filt_hit)
		else $error("1 of 1 crossing did not fire");

	chk_filter_no_cross: assert property (@(posedge sys_clk) disable iff (reset)
		!(sample_valid && sample_cross) |=> !filt_hit)
		else $error("filter fired without a crossing sample");

endmodule

// *** core/alm_top.sv ***
`timescale 1ns/100ps
module alm_top
	import alm_pkg::*;
#(
	parameter int unsigned STEP_CYC = STEP_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wr_data,
	output logic      [7:0]  reg_rd_data,
	input  wire logic [15:0] high_threshold,
	input  wire logic        auto_clear_mode,
	input  wire logic [15:0] photopic_raw,
	input  wire logic [15:0] unfiltered_raw,
	output logic             photopic_channel_on,
	output logic             unfiltered_channel_on,
	output logic             analog_range_low,
	output logic             light_low_current_hold,
	output logic      [15:0] photopic_result,
	output logic      [15:0] unfiltered_result,
	output logic             result_valid,
	output logic             light_int_set,
	output logic             light_int_high,
	output logic             light_int_clear
);

	logic [15:0] low_thr_reg;
	logic [7:0]  filter_reg;
	logic [7:0]  config_reg;
	logic [6:0]  interval_reg;
	logic        ctl_repeat_reg;
	logic        ctl_oneshot_reg;
	alm_state_t  state_reg;
	alm_state_t  state_next;
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic        meas_done;
	logic        wr_control;
	logic        photo_active;
	logic        unf_active;
	logic        cross_high;
	logic        cross_low;
	logic        sample_cross;
	logic        hyst_mode;
	logic        cross_dir_reg;
	logic        clear_next;
	logic        filt_hit;

	// Integration length, 50 ms doubled per code step
	function automatic logic [31:0] integ_len(input logic [1:0] code);
		return 32'(STEP_CYC) << code;
	endfunction

	// Wait between repeats, in 50 ms steps
	function automatic logic [31:0] interval_len(input logic [5:0] ivl);
		return 32'(ivl) * 32'(STEP_CYC);
	endfunction

	assign wr_control = reg_wr_en && reg_addr == ADDR_CONTROL;
	assign meas_done  = state_reg == ST_INTEG && cnt_reg == 32'h0;

	// Both enables clear falls back to photopic only
	assign photo_active = config_reg[CFG_PHO_EN] || !config_reg[CFG_UNF_EN];
	assign unf_active   = config_reg[CFG_UNF_EN];

	// Power only while integrating; off right after each result unless repeating at interval zero
	assign photopic_channel_on   = state_reg == ST_INTEG && photo_active;
	assign unfiltered_channel_on = state_reg == ST_INTEG && unf_active;
	assign analog_range_low      = config_reg[CFG_RANGE_ANALOG];
	// Low current hold between measurements only
	assign light_low_current_hold = interval_reg[IVL_KEEP_PWR] && state_reg != ST_INTEG;

	// Register file

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			low_thr_reg <= {RST_LOW_THR, RST_LOW_THR};
		end else if (reg_wr_en && reg_addr == ADDR_LOW_THR_HIGH) begin
			low_thr_reg[15:8] <= reg_wr_data;
		end else if (reg_wr_en && reg_addr == ADDR_LOW_THR_LOW) begin
			low_thr_reg[7:0] <= reg_wr_data;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			filter_reg <= RST_FILTER;
		end else if (reg_wr_en && reg_addr == ADDR_FILTER) begin
			filter_reg <= reg_wr_data;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			config_reg <= RST_CONFIG;
		end else if (reg_wr_en && reg_addr == ADDR_CONFIG) begin
			config_reg <= reg_wr_data;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			interval_reg <= RST_INTERVAL[6:0];
		end else if (reg_wr_en && reg_addr == ADDR_INTERVAL) begin
			interval_reg <= reg_wr_data[6:0];
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ctl_repeat_reg <= RST_CONTROL[CTL_REPEAT];
		end else if (wr_control) begin
			ctl_repeat_reg <= reg_wr_data[CTL_REPEAT];
		end
	end

	// A software write in the completion cycle wins over the self-clear
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ctl_oneshot_reg <= RST_CONTROL[CTL_ONESHOT];
		end else if (wr_control) begin
			ctl_oneshot_reg <= reg_wr_data[CTL_ONESHOT];
		end else if (meas_done) begin
			ctl_oneshot_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			reg_rd_data <= 8'h00;
		end else if (reg_rd_en) begin
			case (reg_addr)
				ADDR_LOW_THR_HIGH: reg_rd_data <= low_thr_reg[15:8];
				ADDR_LOW_THR_LOW:  reg_rd_data <= low_thr_reg[7:0];
				ADDR_FILTER:       reg_rd_data <= filter_reg;
				ADDR_CONFIG:       reg_rd_data <= config_reg;
				ADDR_INTERVAL:     reg_rd_data <= {1'b0, interval_reg};
				ADDR_CONTROL:      reg_rd_data <= {6'h00, ctl_repeat_reg, ctl_oneshot_reg};
				default:           reg_rd_data <= 8'h00;
			endcase
		end
	end

	// Measurement sequencer

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			ST_IDLE: begin
				if (ctl_oneshot_reg || ctl_repeat_reg) begin
					state_next = ST_INTEG;
					cnt_next   = integ_len(config_reg[CFG_INTEG_HI:CFG_INTEG_LO]) - 32'h1;
				end
			end
			ST_INTEG: begin
				if (cnt_reg != 32'h0) begin
					cnt_next = cnt_reg - 32'h1;
				end else if (!ctl_repeat_reg) begin
					state_next = ST_IDLE;
				end else if (interval_reg[IVL_HI:IVL_LO] == 6'h00) begin
					// Back to back, no gap
					state_next = ST_INTEG;
					cnt_next   = integ_len(config_reg[CFG_INTEG_HI:CFG_INTEG_LO]) - 32'h1;
				end else begin
					state_next = ST_WAIT;
					cnt_next   = interval_len(interval_reg[IVL_HI:IVL_LO]) - 32'h1;
				end
			end
			ST_WAIT: begin
				// Dropping repeat abandons the wait at once
				if (!ctl_repeat_reg) begin
					state_next = ST_IDLE;
				end else if (cnt_reg != 32'h0) begin
					cnt_next = cnt_reg - 32'h1;
				end else begin
					state_next = ST_INTEG;
					cnt_next   = integ_len(config_reg[CFG_INTEG_HI:CFG_INTEG_LO]) - 32'h1;
				end
			end
			default: begin
				state_next = ST_IDLE;
				cnt_next   = 32'h0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 32'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	// Result capture and scaling

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			photopic_result <= 16'h0000;
		end else if (meas_done && photo_active) begin
			if (config_reg[CFG_RANGE_DIV]) begin
				photopic_result <= photopic_raw / RANGE_DIVISOR;
			end else begin
				photopic_result <= photopic_raw;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			unfiltered_result <= 16'h0000;
		end else if (meas_done && unf_active) begin
			if (config_reg[CFG_RANGE_DIV]) begin
				unfiltered_result <= unfiltered_raw / RANGE_DIVISOR;
			end else begin
				unfiltered_result <= unfiltered_raw;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			result_valid <= 1'b0;
		end else begin
			result_valid <= meas_done;
		end
	end

	// Threshold compare, photopic only

	assign cross_high = photo_active && photopic_result > high_threshold;
	assign cross_low  = photo_active && photopic_result < low_thr_reg;
	// Hysteresis only counts under automatic clearing
	assign hyst_mode  = config_reg[CFG_HYST_EN] && auto_clear_mode;

	always_comb begin
		sample_cross = cross_high || cross_low;
		clear_next   = 1'b0;
		if (hyst_mode) begin
			if (config_reg[CFG_HYST_UP]) begin
				sample_cross = cross_high;
				clear_next   = result_valid && cross_low;
			end else begin
				sample_cross = cross_low;
				clear_next   = result_valid && cross_high;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cross_dir_reg <= 1'b0;
		end else if (result_valid) begin
			cross_dir_reg <= cross_high;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			light_int_clear <= 1'b0;
		end else begin
			light_int_clear <= clear_next;
		end
	end

	alm_filter #(
		.HIST_W(FILT_HIST)
	) u_filter (
		.sys_clk      (sys_clk),
		.reset        (reset),
		.sample_valid (result_valid),
		.sample_cross (sample_cross),
		.win_n        (filter_reg[FILT_N_HI:FILT_N_LO]),
		.hits_m       (filter_reg[FILT_M_HI:FILT_M_LO]),
		.filt_hit     (filt_hit)
	);

	assign light_int_set  = filt_hit;
	assign light_int_high = cross_dir_reg;

	// Checks

	sequence seq_repeat_end;
		meas_done && ctl_repeat_reg;
	endsequence

	sequence seq_single_end;
		meas_done && !ctl_repeat_reg && !wr_control;
	endsequence

	chk_thr_high_write: assert property (@(posedge sys_clk) disable iff (reset)
		(reg_wr_en && reg_addr == ADDR_LOW_THR_HIGH) |=> low_thr_reg[15:8] == $past(reg_wr_data))
		else $error("low threshold high byte not written");

	chk_chan_power_sel: assert property (@(posedge sys_clk) disable iff (reset)
		(state_reg == ST_INTEG && config_reg[7:6] == 2'b00) |-> photopic_channel_on)
		else $error("photopic channel off with both enables clear");

	chk_power_down_idle: assert property (@(posedge sys_clk) disable iff (reset)
		(meas_done && !(ctl_repeat_reg && interval_reg[IVL_HI:IVL_LO] == 6'h00))
		|=> !photopic_channel_on && !unfiltered_channel_on)
		else $error("channel still powered after measurement");

	chk_oneshot_self_clear: assert property (@(posedge sys_clk) disable iff (reset)
		seq_single_end |=> !ctl_oneshot_reg && state_reg == ST_IDLE)
		else $error("single shot did not complete and clear");

	chk_continuous_loop: assert property (@(posedge sys_clk) disable iff (reset)
		seq_repeat_end ##0 interval_reg[5:0] == 6'h00 |=> state_reg == ST_INTEG)
		else $error("zero interval did not restart at once");

	chk_interval_load: assert property (@(posedge sys_clk) disable iff (reset)
		seq_repeat_end ##0 interval_reg[5:0] != 6'h00 |=> state_reg == ST_WAIT
		&& cnt_reg == interval_len($past(interval_reg[5:0])) - 32'h1)
		else $error("repeat wait not loaded with interval");

	chk_repeat_restart: assert property (@(posedge sys_clk) disable iff (reset)
		(state_reg == ST_WAIT && cnt_reg == 32'h0 && ctl_repeat_reg) |=> state_reg == ST_INTEG)
		else $error("repeat did not start next measurement");

	chk_div_ten_scale: assert property (@(posedge sys_clk) disable iff (reset)
		(meas_done && photo_active && config_reg[3]) |=>
		photopic_result == $past(photopic_raw) / 16'h000a ##1 !result_valid)
		else $error("divide by ten scaling wrong");

	chk_window_cross: assert property (@(posedge sys_clk) disable iff (reset)
		(result_valid && !hyst_mode && photopic_result < low_thr_reg) |-> sample_cross)
		else $error("below window not flagged");

	chk_clear_needs_auto: assert property (@(posedge sys_clk) disable iff (reset)
		(result_valid && !auto_clear_mode) |=> !light_int_clear)
		else $error("clear pulse outside automatic clearing");

	chk_unf_no_cross: assert property (@(posedge sys_clk) disable iff (reset)
		(result_valid && !photo_active) |-> !sample_cross)
		else $error("crossing flagged without photopic result");

	chk_int_after_result: assert property (@(posedge sys_clk) disable iff (reset)
		light_int_set |-> $past(result_valid))
		else $error("interrupt set without a fresh result");

endmodule

// *** test/alm_sensor_model.sv ***
`timescale 1ns/100ps
module alm_sensor_model (
	input  wire logic        sys_clk,
	input  wire logic        photopic_channel_on,
	input  wire logic        unfiltered_channel_on,
	input  wire logic [15:0] pho_level,
	input  wire logic [15:0] unf_level,
	output logic      [15:0] photopic_raw,
	output logic      [15:0] unfiltered_raw
);
	// An unpowered converter gives no count, so the last one is inverted every cycle
	always @(posedge sys_clk) begin
		photopic_raw <= photopic_channel_on ? pho_level : ~photopic_raw;
		unfiltered_raw <= unfiltered_channel_on ? unf_level : ~unfiltered_raw;
	end
endmodule

// *** test/ambient_light_measure_control_tb.sv ***
`timescale 1ns/100ps
module ambient_light_measure_control_tb;
	logic        sys_clk = 1'b0;
	logic        reset;
	logic        reg_wr_en, reg_rd_en;
	logic [7:0]  reg_addr, reg_wr_data, reg_rd_data;
	logic [15:0] high_threshold, photopic_raw, unfiltered_raw, pho_level, unf_level;
	logic        auto_clear_mode;
	logic        photopic_channel_on, unfiltered_channel_on, analog_range_low;
	logic        light_low_current_hold, result_valid;
	logic [15:0] photopic_result, unfiltered_result;
	logic        light_int_set, light_int_high, light_int_clear;
	int          n_errors = 0;
	int          comparisons = 0;
	int          cycles = 0;
	logic [7:0]  ra [7] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h30};
	logic [7:0]  rv [7] = '{8'h00, 8'h00, 8'h11, 8'h40, 8'h0a, 8'h00, 8'h00};

	always #25 sys_clk = ~sys_clk;

	// Short measurement step keeps every integration a few cycles long
	alm_top #(.STEP_CYC(4)) u_dut (
		.sys_clk(sys_clk), .reset(reset), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
		.high_threshold(high_threshold), .auto_clear_mode(auto_clear_mode),
		.photopic_raw(photopic_raw), .unfiltered_raw(unfiltered_raw),
		.photopic_channel_on(photopic_channel_on),
		.unfiltered_channel_on(unfiltered_channel_on), .analog_range_low(analog_range_low),
		.light_low_current_hold(light_low_current_hold), .photopic_result(photopic_result),
		.unfiltered_result(unfiltered_result), .result_valid(result_valid),
		.light_int_set(light_int_set), .light_int_high(light_int_high),
		.light_int_clear(light_int_clear)
	);

	alm_sensor_model u_model (
		.sys_clk(sys_clk), .photopic_channel_on(photopic_channel_on),
		.unfiltered_channel_on(unfiltered_channel_on), .pho_level(pho_level),
		.unf_level(unf_level), .photopic_raw(photopic_raw), .unfiltered_raw(unfiltered_raw)
	);

	task automatic end_sim;
		if (n_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp);
		comparisons++;
		if (got != exp) begin
			n_errors++;
			$display("CHECK FAILED %0t count %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr_en <= 1'b1;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge sys_clk);
		reg_rd_en <= 1'b0;
		#1;
		chk_val({8'h00, reg_rd_data}, {8'h00, exp});
	endtask

	// One single-shot measurement; counts powered cycles of each channel
	task automatic shot(input logic [7:0] cfg, input logic [15:0] pl, input logic [15:0] ul,
		input int pc, input int uc, input logic [15:0] res, input logic is, input logic ic);
		int np, nu, k;
		np = 0;
		nu = 0;
		wr(8'h25, cfg);
		pho_level <= pl;
		unf_level <= ul;
		wr(8'h27, 8'h01);
		for (k = 0; k < 200; k++) begin
			@(posedge sys_clk);
			#1;
			if (result_valid === 1'b1)
				break;
			np += (photopic_channel_on === 1'b1);
			nu += (unfiltered_channel_on === 1'b1);
		end
		chk_cnt(np, pc);
		chk_cnt(nu, uc);
		chk_val(photopic_result, res);
		@(posedge sys_clk);
		#1;
		chk_val({15'h0000, light_int_set}, {15'h0000, is});
		chk_val({15'h0000, light_int_clear}, {15'h0000, ic});
	endtask

	// Cycles from one result to the next in repeat mode
	task automatic gap(input int exp, input logic hold);
		int k, n;
		n = 0;
		for (k = 0; k < 100 && result_valid !== 1'b1; k++) begin
			@(posedge sys_clk);
			#1;
		end
		chk_val({15'h0000, light_low_current_hold}, {15'h0000, hold});
		for (k = 0; k < 100; k++) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (result_valid === 1'b1)
				break;
		end
		chk_cnt(n, exp);
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			n_errors++;
			end_sim();
		end
	end

	initial begin
		int nv;
		reset = 1'b1;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 8'h00;
		reg_wr_data = 8'h00;
		high_threshold = 16'h8000;
		auto_clear_mode = 1'b0;
		pho_level = 16'h0000;
		unf_level = 16'h0000;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		for (int i = 0; i < 7; i++)
			rd(ra[i], rv[i]);
		// First result after reset is thrown away
		wr(8'h27, 8'h01);
		repeat (8) @(posedge sys_clk);
		wr(8'h22, 8'h12);
		wr(8'h23, 8'h34);
		rd(8'h22, 8'h12);
		rd(8'h23, 8'h34);
		wr(8'h26, 8'hff);
		rd(8'h26, 8'h7f);
		chk_val({15'h0000, light_low_current_hold}, 16'h0001);
		wr(8'h30, 8'h55);
		rd(8'h30, 8'h00);
		for (int c = 0; c < 4; c++)
			shot(8'h40 | 8'(c), 16'h0100, 16'h0000, 4 << c, 0, 16'h0100, 1'b1, 1'b0);
		rd(8'h27, 8'h00);
		shot(8'hc0, 16'h2000, 16'h0001, 4, 4, 16'h2000, 1'b0, 1'b0);
		chk_val(unfiltered_result, 16'h0001);
		shot(8'h00, 16'h9000, 16'h0000, 4, 0, 16'h9000, 1'b1, 1'b0);
		shot(8'h48, 16'h0107, 16'h0000, 4, 0, 16'h001a, 1'b1, 1'b0);
		chk_val({15'h0000, analog_range_low}, 16'h0000);
		shot(8'h4c, 16'h0107, 16'h0000, 4, 0, 16'h001a, 1'b1, 1'b0);
		chk_val({15'h0000, analog_range_low}, 16'h0001);
		shot(8'h44, 16'h2005, 16'h0000, 4, 0, 16'h2005, 1'b0, 1'b0);
		wr(8'h24, 8'h01);
		shot(8'h40, 16'h0100, 16'h0000, 4, 0, 16'h0100, 1'b0, 1'b0);
		wr(8'h24, 8'h10);
		shot(8'h40, 16'h0100, 16'h0000, 4, 0, 16'h0100, 1'b0, 1'b0);
		// Window of three, two hits needed
		wr(8'h24, 8'h32);
		shot(8'h40, 16'h2000, 16'h0000, 4, 0, 16'h2000, 1'b0, 1'b0);
		shot(8'h40, 16'h2000, 16'h0000, 4, 0, 16'h2000, 1'b0, 1'b0);
		shot(8'h40, 16'h0100, 16'h0000, 4, 0, 16'h0100, 1'b0, 1'b0);
		shot(8'h40, 16'h0100, 16'h0000, 4, 0, 16'h0100, 1'b1, 1'b0);
		wr(8'h24, 8'h11);
		@(posedge sys_clk);
		auto_clear_mode <= 1'b1;
		shot(8'h60, 16'h0100, 16'h0000, 4, 0, 16'h0100, 1'b1, 1'b0);
		chk_val({15'h0000, light_int_high}, 16'h0000);
		shot(8'h60, 16'h9000, 16'h0000, 4, 0, 16'h9000, 1'b0, 1'b1);
		shot(8'h70, 16'h9000, 16'h0000, 4, 0, 16'h9000, 1'b1, 1'b0);
		chk_val({15'h0000, light_int_high}, 16'h0001);
		@(posedge sys_clk);
		auto_clear_mode <= 1'b0;
		shot(8'h60, 16'h9000, 16'h0000, 4, 0, 16'h9000, 1'b1, 1'b0);
		wr(8'h26, 8'h42);
		wr(8'h27, 8'h02);
		gap(12, 1'b1);
		wr(8'h27, 8'h00);
		repeat (8) @(posedge sys_clk);
		nv = 0;
		repeat (30) begin
			@(posedge sys_clk);
			#1;
			nv += (result_valid !== 1'b0);
		end
		chk_cnt(nv, 0);
		wr(8'h26, 8'h00);
		wr(8'h27, 8'h02);
		gap(4, 1'b0);
		wr(8'h27, 8'h00);
		repeat (10) @(posedge sys_clk);
		end_sim();
	end
endmodule
